// ===== rtl/pcw_defs.svh
// Constants of the potentiometer control and wiper code block.
// Assumes inclusion by the package and design files by bare name.
`ifndef PCW_DEFS_SVH
`define PCW_DEFS_SVH
`define PCW_CMD_NOP       4'h0
`define PCW_CMD_WR_WIPER  4'h1
`define PCW_CMD_RD_WIPER  4'h2
`define PCW_CMD_SW_RESET  4'h4
`define PCW_CMD_WR_CONFIG 4'h6
`define PCW_CMD_RD_CONFIG 4'h7
`define PCW_CMD_SHUTDOWN  4'h8
`define PCW_CAL_POS       2
`define PCW_UNLOCK_POS    1
`define PCW_SHDN_POS      0
`define PCW_CAL_RST       1'b0
`define PCW_UNLOCK_RST    1'b0
`define PCW_WIPER_MID     10'h200
`define PCW_FRAME_BITS    16
`endif

// ===== rtl/pcw_pkg.sv
// Types shared by the potentiometer control block, its host model and its bench.
// Assumes pcw_defs.svh is on the include path.
`include "pcw_defs.svh"
package pcw_pkg;
    typedef struct packed {
        logic       valid;
        logic [3:0] cmd;
        logic [9:0] data;
    } pcw_frame_t;
    typedef struct packed {
        logic cal_select;
        logic wiper_write_unlock;
    } pcw_config_t;
endpackage

// ===== rtl/pcw_tap_decode.sv
// One-hot tap decoder for the wiper code.
// Assumes a stable registered code at its input.
module pcw_tap_decode #(
    parameter int CODE_W = 10
) (
    // Code in.
    input  wire logic [CODE_W-1:0]      code,
    // One tap select per position, bit 0 at the B end.
    output logic      [(1<<CODE_W)-1:0] tap_sel
);
    always_comb
    begin
        tap_sel       = '0;
        tap_sel[code] = 1'b1;
    end
endmodule // pcw_tap_decode

// ===== rtl/pcw_ctrl.sv
// Control register, wiper code register and frame readback.
// Assumes decoded command frames arrive as one-cycle valid pulses
// and that the reset pin has been synchronised to clk.
//
// What this block does
// - Config data keeps calibration select at D2 and unlock at D1.
// - Calibration select resets to 0 and 1 selects normal mode.
// - Unlock resets to 0 blocking wiper writes and 1 allows them.
// - The 10-bit wiper code selects exactly one of 1024 taps.
// - Code D selects the tap D steps from the B end.
// - Command 0110 writes the config from D2 and D1.
// - Wiper writes are ignored while locked; only resets recentre.
// - Software reset or a reset pin rise loads midscale and config defaults; shutdown keeps its state.
// - Command 0111 returns the config in the next frame.
`include "pcw_defs.svh"
module pcw_ctrl #(
    parameter int CODE_W = 10,
    parameter int TAPS   = 1024
) (
    // Clock and reset.
    input  wire logic                    clk,
    input  wire logic                    rst_b,
    // Command frames and the reset pin.
    input  wire pcw_pkg::pcw_frame_t     frame_in,
    input  wire logic                    reset_pin,
    // Readback word for the next frame.
    output logic [`PCW_FRAME_BITS-1:0]   serial_readback_out,
    // State seen by the analog side.
    output pcw_pkg::pcw_config_t         config_out,
    output logic                         shutdown_out,
    output logic [CODE_W-1:0]            wiper_code_out,
    output logic [TAPS-1:0]              tap_sel
);
    import pcw_pkg::*;

    if (CODE_W != 10 || TAPS != (1 << CODE_W))
    begin : g_bad_params
        $error("pcw_ctrl: CODE_W must be 10 and TAPS 2**CODE_W");
    end

    ////////////////////////////////////////////////////////////////////
    pcw_config_t       pot_config_reg;
    logic [9:0]        wiper_code_reg;
    logic              shutdown_reg;
    logic              reset_pin_reg;
    logic [15:0]       readback_reg;
    logic              pin_rise;
    logic              sw_reset;

    function automatic logic is_cmd(pcw_frame_t f, logic [3:0] c);
        return f.valid && f.cmd == c;
    endfunction

    assign pin_rise = reset_pin && !reset_pin_reg;
    assign sw_reset = frame_in.valid && frame_in.cmd == `PCW_CMD_SW_RESET;

    always_ff @(posedge clk)
    begin
        reset_pin_reg <= reset_pin;
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk)
    begin
        if (!rst_b || pin_rise || sw_reset)
        begin
            pot_config_reg.cal_select         <= `PCW_CAL_RST;
            pot_config_reg.wiper_write_unlock <= `PCW_UNLOCK_RST;
        end
        else if (frame_in.valid && frame_in.cmd == `PCW_CMD_WR_CONFIG)
        begin
            pot_config_reg.cal_select <=
                frame_in.data[`PCW_CAL_POS];
            pot_config_reg.wiper_write_unlock <=
                frame_in.data[`PCW_UNLOCK_POS];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b || pin_rise || sw_reset)
            wiper_code_reg <= `PCW_WIPER_MID;
        else if (frame_in.valid && frame_in.cmd == `PCW_CMD_WR_WIPER
                 && pot_config_reg.wiper_write_unlock)
            wiper_code_reg <= frame_in.data;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            shutdown_reg <= 1'b0;
        else if (frame_in.valid && frame_in.cmd == `PCW_CMD_SHUTDOWN)
            shutdown_reg <= frame_in.data[`PCW_SHDN_POS];
    end

    ////////////////////////////////////////////////////////////////////
    // Each frame loads what the next frame shifts out: an echo of
    // itself, or the requested register.
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            readback_reg <= 16'h0000;
        else if (frame_in.valid)
        begin
            unique case (frame_in.cmd)
                `PCW_CMD_RD_CONFIG:
                    readback_reg <= {6'h00, 7'h00,
                        pot_config_reg.cal_select,
                        pot_config_reg.wiper_write_unlock, 1'b0};
                `PCW_CMD_RD_WIPER:
                    readback_reg <= {6'h00, wiper_code_reg};
                default:
                    readback_reg <= {2'h0, frame_in.cmd, frame_in.data};
            endcase
        end
    end

    assign serial_readback_out = readback_reg;
    assign config_out          = pot_config_reg;
    assign shutdown_out        = shutdown_reg;
    assign wiper_code_out      = wiper_code_reg;

    pcw_tap_decode #(
        .CODE_W (CODE_W)
    ) u_dec (
        .code    (wiper_code_reg),
        .tap_sel (tap_sel)
    );

    ////////////////////////////////////////////////////////////////////
    AST_LOCKED_HOLD:
        assert property (@(posedge clk) disable iff (!rst_b)
            is_cmd(frame_in, `PCW_CMD_WR_WIPER)
            && !pot_config_reg.wiper_write_unlock && !pin_rise
            |=> $stable(wiper_code_reg))
        else $error("Locked wiper write changed the code.");

    AST_LOCKED_TAPS:
        assert property (@(posedge clk) disable iff (!rst_b)
            is_cmd(frame_in, `PCW_CMD_WR_WIPER)
            && !pot_config_reg.wiper_write_unlock && !$rose(reset_pin)
            |=> $stable(tap_sel))
        else $error("Locked wiper write moved the tap.");

    AST_UNLOCKED_WRITE:
        assert property (@(posedge clk) disable iff (!rst_b)
            is_cmd(frame_in, `PCW_CMD_WR_WIPER)
            && pot_config_reg.wiper_write_unlock && !pin_rise
            |=> wiper_code_reg == $past(frame_in.data))
        else $error("Unlocked wiper write was lost.");

    AST_CFG_WRITE:
        assert property (@(posedge clk) disable iff (!rst_b)
            is_cmd(frame_in, `PCW_CMD_WR_CONFIG) && !pin_rise
            |=> pot_config_reg.cal_select
                == $past(frame_in.data[`PCW_CAL_POS])
            && pot_config_reg.wiper_write_unlock
                == $past(frame_in.data[`PCW_UNLOCK_POS]))
        else $error("Config write took the wrong bits.");

    AST_SW_RESET:
        assert property (@(posedge clk) disable iff (!rst_b)
            is_cmd(frame_in, `PCW_CMD_SW_RESET)
            |=> wiper_code_reg == `PCW_WIPER_MID
            && pot_config_reg == {`PCW_CAL_RST, `PCW_UNLOCK_RST})
        else $error("Software reset did not restore defaults.");

    AST_PIN_RESET:
        assert property (@(posedge clk) disable iff (!rst_b)
            $rose(reset_pin)
            |=> wiper_code_reg == `PCW_WIPER_MID
            && pot_config_reg == {`PCW_CAL_RST, `PCW_UNLOCK_RST})
        else $error("Reset pin rise did not recentre the wiper.");

    AST_PIN_BEATS_WRITE:
        assert property (@(posedge clk) disable iff (!rst_b)
            $rose(reset_pin) && is_cmd(frame_in, `PCW_CMD_WR_WIPER)
            |=> wiper_code_reg == `PCW_WIPER_MID)
        else $error("Wiper write beat a reset pin rise.");

    AST_RESET_DEFAULT:
        assert property (@(posedge clk)
            !rst_b
            |=> pot_config_reg == {`PCW_CAL_RST, `PCW_UNLOCK_RST}
            && wiper_code_reg == `PCW_WIPER_MID)
        else $error("Reset defaults are wrong.");

    AST_WIPER_HOLD:
        assert property (@(posedge clk) disable iff (!rst_b)
            !is_cmd(frame_in, `PCW_CMD_WR_WIPER)
            && !is_cmd(frame_in, `PCW_CMD_SW_RESET) && !$rose(reset_pin)
            |=> $stable(wiper_code_reg))
        else $error("Wiper code moved without a write or reset.");

    AST_CFG_HOLD:
        assert property (@(posedge clk) disable iff (!rst_b)
            !is_cmd(frame_in, `PCW_CMD_WR_CONFIG)
            && !is_cmd(frame_in, `PCW_CMD_SW_RESET) && !$rose(reset_pin)
            |=> $stable(pot_config_reg))
        else $error("Config moved without a write or reset.");

    AST_CFG_READ:
        assert property (@(posedge clk) disable iff (!rst_b)
            is_cmd(frame_in, `PCW_CMD_RD_CONFIG)
            |=> serial_readback_out
                == {13'h0000, $past(pot_config_reg), 1'b0})
        else $error("Config readback is wrong.");

    AST_WIPER_READ:
        assert property (@(posedge clk) disable iff (!rst_b)
            is_cmd(frame_in, `PCW_CMD_RD_WIPER)
            |=> serial_readback_out
                == {6'h00, $past(wiper_code_reg)})
        else $error("Wiper readback is wrong.");

    AST_ECHO:
        assert property (@(posedge clk) disable iff (!rst_b)
            frame_in.valid && frame_in.cmd != `PCW_CMD_RD_CONFIG
            && frame_in.cmd != `PCW_CMD_RD_WIPER
            |=> serial_readback_out
                == {2'h0, $past(frame_in.cmd), $past(frame_in.data)})
        else $error("Frame echo is wrong.");

    AST_ONE_HOT:
        assert property (@(posedge clk) disable iff (!rst_b)
            $onehot(tap_sel) && tap_sel[wiper_code_reg])
        else $error("Tap select does not match the code.");
endmodule // pcw_ctrl

// ===== bench/pcw_host_model.sv
// Host model that issues decoded command frames to the control block.
// Assumes the bench calls send and that clk runs freely.
module pcw_host_model (
    // Clock and frame out.
    input  wire logic        clk,
    output pcw_pkg::pcw_frame_t frame
);
    timeunit 1ns;
    timeprecision 1ps;
    import pcw_pkg::*;
    initial frame = '0;
    // Sends one frame as a one-cycle pulse, then drives junk.
    task automatic send(input logic [3:0] cmd, input logic [9:0] data);
        @(negedge clk);
        frame = '{1'b1, cmd, data};
        @(negedge clk);
        frame = '{1'b0, ~cmd, ~data};
    endtask
endmodule // pcw_host_model

// ===== bench/testbench.sv
// Self-checking bench for the control and wiper code block.
// Assumes the host model supplies frames after falling edges.
`define CHK(nm, e, g) \
    begin \
        comparisons++; \
        if ((g) !== (e)) \
        begin \
            fail_count++; \
            $display("ERROR %s expected %h seen %h", nm, e, g); \
        end \
    end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import pcw_pkg::*;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        reset_pin = 1'b0;
    pcw_frame_t  frame;
    logic [15:0] rb;
    pcw_config_t cfg;
    logic [9:0]  wc;
    logic        sd;
    logic [1023:0] taps;
    int          fail_count = 0;
    int          comparisons = 0;
    always #5 clk = ~clk;
    pcw_host_model host (.clk(clk), .frame(frame));
    pcw_ctrl dut (.clk(clk), .rst_b(rst_b), .frame_in(frame),
        .reset_pin(reset_pin), .serial_readback_out(rb),
        .config_out(cfg), .shutdown_out(sd), .wiper_code_out(wc),
        .tap_sel(taps));
    ////////////////////////////////////////////////////////////////////
    task t_defaults;
        `CHK("cfg", 2'b00, cfg)
        `CHK("unlock", 1'b0, cfg.wiper_write_unlock)
        `CHK("wiper", 10'h200, wc)
        `CHK("tap mid", 1'b1, taps[512])
    endtask
    task t_locked;
        host.send(4'h1, 10'h100);
        `CHK("locked wiper", 10'h200, wc)
    endtask
    task t_config;
        host.send(4'h6, 10'h3FB);
        `CHK("cfg junk", 2'b01, cfg)
        host.send(4'h6, 10'h004);
        `CHK("cfg normal", 2'b10, cfg)
        host.send(4'h7, 10'h000);
        `CHK("cfg read", 16'h0004, rb)
        host.send(4'h6, 10'h002);
        `CHK("cfg unlock", 2'b01, cfg)
    endtask
    task t_wiper;
        logic [9:0] c [3];
        c = '{10'h000, 10'h100, 10'h3FF};
        foreach (c[i])
        begin
            host.send(4'h1, c[i]);
            `CHK("wiper", c[i], wc)
            `CHK("taps", 1024'h1 << c[i], taps)
        end
    endtask
    task t_readback;
        host.send(4'h6, 10'h002);
        `CHK("echo", 16'h1802, rb)
        host.send(4'h1, 10'h1C3);
        host.send(4'h2, 10'h000);
        `CHK("wiper read", 16'h01C3, rb)
        host.send(4'h0, 10'h3FF);
        `CHK("nop echo", 16'h03FF, rb)
        host.send(4'h8, 10'h001);
        `CHK("shutdown on", 1'b1, sd)
        `CHK("shutdown wiper", 10'h1C3, wc)
        `CHK("shutdown cfg", 2'b01, cfg)
        host.send(4'h8, 10'h000);
        `CHK("shutdown off", 1'b0, sd)
    endtask
    task t_mid_reset;
        host.send(4'h6, 10'h006);
        host.send(4'h1, 10'h2A5);
        `CHK("pre rst wiper", 10'h2A5, wc)
        `CHK("pre rst cfg", 2'b11, cfg)
        rst_b = 1'b0;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        `CHK("rst cfg", 2'b00, cfg)
        `CHK("rst wiper", 10'h200, wc)
        `CHK("rst readback", 16'h0000, rb)
        @(negedge clk);
    endtask
    task t_resets;
        host.send(4'h6, 10'h006);
        host.send(4'h1, 10'h321);
        `CHK("pre sw wiper", 10'h321, wc)
        host.send(4'h4, 10'h000);
        `CHK("sw wiper", 10'h200, wc)
        `CHK("sw cfg", 2'b00, cfg)
        host.send(4'h6, 10'h002);
        host.send(4'h1, 10'h055);
        `CHK("pre pin", 10'h055, wc)
        reset_pin = 1'b1;
        @(negedge clk);
        `CHK("pin wiper", 10'h200, wc)
        `CHK("pin cfg", 2'b00, cfg)
        reset_pin = 1'b0;
        host.send(4'h6, 10'h002);
        host.send(4'h1, 10'h0AA);
        `CHK("pre race", 10'h0AA, wc)
        fork
            host.send(4'h1, 10'h155);
            begin
                @(negedge clk);
                reset_pin = 1'b1;
            end
        join
        `CHK("race wiper", 10'h200, wc)
        `CHK("race cfg", 2'b00, cfg)
        reset_pin = 1'b0;
    endtask
    task give_verdict;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // The scenarios take well under 200 cycles; allow ten times that.
    initial
    begin
        #20000;
        fail_count++;
        give_verdict;
    end
    initial
    begin
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        t_defaults;
        t_locked;
        t_config;
        t_wiper;
        t_readback;
        t_mid_reset;
        t_resets;
        give_verdict;
    end
endmodule // testbench
